// ==== hdl/hwc_halt_ctrl.sv ====
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`include "hwc_params.svh"

module hwc_halt_ctrl #(
  parameter int PLL_STARTUP_NS = `HWC_PLL_STARTUP_NS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic wdg_active_in,
  input wire hwc_pkg::hwc_wake_src_t wake_src_in,
  input wire logic irq_entry_in,
  input wire logic [1:0] irq_level_in,
  input wire logic cc_pop_in,
  input wire logic [1:0] cc_pop_mask_in,
  input wire logic wake_rc_clk_in,
  output hwc_pkg::hwc_clk_ctrl_t clk_ctrl_out,
  output logic cap_route_out,
  output logic clr_mask_out,
  output logic [1:0] int_mask_out,
  output logic resume_reset_out,
  output logic resume_irq_out,
  output logic wdg_reset_out,
  output logic wake_irq_out
);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  localparam int PLL_CYC_I =
    (PLL_STARTUP_NS + `HWC_CLK_PERIOD_NS - 1) / `HWC_CLK_PERIOD_NS;
  localparam logic [`HWC_TMR_W-1:0] PLL_CYC = `HWC_TMR_W'(PLL_CYC_I);

  if (PLL_CYC_I < 1 || PLL_CYC_I > (1 << `HWC_TMR_W) - 1) begin : g_chk
    $error("PLL startup count does not fit the cycle timer");
  end

  localparam hwc_pkg::hwc_top_st_t RST_ST = '{
    state: hwc_pkg::HWC_RUN,
    prescaler: `HWC_PRESCALER_RST,
    cfg: `HWC_CFG_RST,
    clk: '{main_osc: 1'b1, timer_clk: 1'b1, periph_clk: 1'b1,
           pll_clk: 1'b0, rc_en: 1'b0, cpu_run: 1'b1},
    default: '0
  };

  function automatic logic reg_hit(input logic [9:0] adr,
                                   input logic [7:0] idx);
    reg_hit = (adr[9:2] == idx);
  endfunction

  hwc_pkg::hwc_top_st_t st_ff;
  hwc_pkg::hwc_top_st_t nxt_st;
  logic tmr_start;
  logic [`HWC_TMR_W-1:0] tmr_load;
  logic tmr_done;
  logic expire;
  logic bus_req;
  logic timed_en;
  logic halt_op;
  logic csr_read;
  logic rc_tick;
  logic [`HWC_TMR_W-1:0] stab_len;

  assign timed_en = st_ff.cfg[`HWC_CFG_TIME_BASE1_INT_ENABLE] |
                    (st_ff.cfg[`HWC_CFG_OVERFLOW_INT_ENABLE] & ~st_ff.cfg[`HWC_CFG_CK1] &
                     st_ff.cfg[`HWC_CFG_CK0]);
  assign halt_op = opcode_valid_in && (opcode_in == `HWC_HALT_OPCODE);
  assign bus_req = wb_cyc_in && wb_stb_in && !st_ff.ack;
  assign csr_read = bus_req && !wb_we_in && reg_hit(wb_adr_in, `HWC_IDX_CSR);
  assign rc_tick = st_ff.rc_s2 ^ st_ff.rc_s3;
  assign stab_len = st_ff.cfg[`HWC_CFG_LONG] ? `HWC_STAB_LONG :
                                               `HWC_STAB_SHORT;

  always_comb begin
    nxt_st = st_ff;
    tmr_start = 1'b0;
    tmr_load = stab_len;
    nxt_st.clr_mask = 1'b0;
    nxt_st.resume_reset = 1'b0;
    nxt_st.resume_irq = 1'b0;
    nxt_st.wdg_rst = 1'b0;
    nxt_st.rc_s1 = wake_rc_clk_in;
    nxt_st.rc_s2 = st_ff.rc_s1;
    nxt_st.rc_s3 = st_ff.rc_s2;

    // Register bus: one wait state, write and read at the ack edge
    nxt_st.ack = bus_req;
    nxt_st.rdata = '0;
    if (bus_req && wb_we_in && wb_sel_in[0]) begin
      if (reg_hit(wb_adr_in, `HWC_IDX_PRESCALER)) begin
        if (wb_dat_in[7:0] != 8'h00) begin
          nxt_st.prescaler = wb_dat_in[7:0];
        end
      end else if (reg_hit(wb_adr_in, `HWC_IDX_CSR)) begin
        nxt_st.wake_en = wb_dat_in[`HWC_CSR_EN];
        nxt_st.meas_en = wb_dat_in[`HWC_CSR_MEAS];
      end else if (reg_hit(wb_adr_in, `HWC_IDX_CFG)) begin
        nxt_st.cfg = wb_dat_in[6:0];
      end
    end
    if (bus_req && !wb_we_in) begin
      if (reg_hit(wb_adr_in, `HWC_IDX_PRESCALER)) begin
        nxt_st.rdata = st_ff.prescaler;
      end else if (reg_hit(wb_adr_in, `HWC_IDX_CSR)) begin
        nxt_st.rdata = {5'h00, st_ff.wake_flag, st_ff.meas_en, st_ff.wake_en};
      end else if (reg_hit(wb_adr_in, `HWC_IDX_CFG)) begin
        nxt_st.rdata = {1'b0, st_ff.cfg};
      end else if (reg_hit(wb_adr_in, `HWC_IDX_STAT)) begin
        nxt_st.rdata = {3'h0, st_ff.mask, 3'(st_ff.state)};
      end
    end
    // Read clears flag and pending interrupt
    if (csr_read) begin
      nxt_st.wake_flag = 1'b0;
      nxt_st.wake_irq = 1'b0;
    end

    // Mask follows interrupt entry and pop
    if (irq_entry_in) begin
      nxt_st.mask = irq_level_in;
    end else if (cc_pop_in) begin
      nxt_st.mask = cc_pop_mask_in;
    end

    unique case (st_ff.state)
      hwc_pkg::HWC_RUN: begin
        if (halt_op) begin
          // Watchdog reset only outside timed halt
          if (wdg_active_in && !timed_en && st_ff.cfg[`HWC_CFG_WDGOPT]) begin
            nxt_st.wdg_rst = 1'b1;
          end else begin
            // Mask cleared on any halt entry
            nxt_st.clr_mask = 1'b1;
            nxt_st.mask = 2'b00;
            nxt_st.clk.cpu_run = 1'b0;
            nxt_st.clk.periph_clk = 1'b0;
            nxt_st.clk.pll_clk = 1'b0;
            if (st_ff.wake_en) begin
              nxt_st.state = hwc_pkg::HWC_WAKE;
              nxt_st.clk.main_osc = 1'b0;
              nxt_st.clk.timer_clk = 1'b0;
            end else if (timed_en) begin
              nxt_st.state = hwc_pkg::HWC_TIMED;
            end else begin
              nxt_st.state = hwc_pkg::HWC_PLAIN;
              nxt_st.clk.main_osc = 1'b0;
              nxt_st.clk.timer_clk = 1'b0;
            end
          end
        end
      end
      hwc_pkg::HWC_TIMED: begin
        // Only reset or designated interrupts end it
        if (wake_src_in.reset_req) begin
          nxt_st.by_reset = 1'b1;
          nxt_st.state = hwc_pkg::HWC_STAB;
          tmr_start = 1'b1;
        end else if (wake_src_in.irq_real_time_base1_interrupt || wake_src_in.irq_active_exit) begin
          nxt_st.state = hwc_pkg::HWC_RUN;
          nxt_st.resume_irq = 1'b1;
          nxt_st.clk.cpu_run = 1'b1;
          nxt_st.clk.periph_clk = 1'b1;
          nxt_st.clk.pll_clk = st_ff.cfg[`HWC_CFG_PLLEN];
        end
      end
      hwc_pkg::HWC_PLAIN, hwc_pkg::HWC_WAKE: begin
        // Exit by reset, halt-exit interrupt or wake delay
        if (wake_src_in.reset_req || wake_src_in.irq_halt_exit ||
            (expire && st_ff.state == hwc_pkg::HWC_WAKE)) begin
          nxt_st.by_reset = wake_src_in.reset_req;
          nxt_st.state = hwc_pkg::HWC_STAB;
          nxt_st.clk.main_osc = 1'b1;
          tmr_start = 1'b1;
        end
      end
      hwc_pkg::HWC_STAB: begin
        if (tmr_done) begin
          if (st_ff.cfg[`HWC_CFG_PLLEN]) begin
            nxt_st.state = hwc_pkg::HWC_PLL;
            tmr_start = 1'b1;
            tmr_load = PLL_CYC;
          end else begin
            nxt_st.state = hwc_pkg::HWC_RUN;
          end
        end
      end
      hwc_pkg::HWC_PLL: begin
        if (tmr_done) begin
          nxt_st.state = hwc_pkg::HWC_RUN;
        end
      end
      default: begin
        nxt_st.state = hwc_pkg::HWC_RUN;
      end
    endcase

    // Resume after delays, vector by cause
    if (nxt_st.state == hwc_pkg::HWC_RUN &&
        (st_ff.state == hwc_pkg::HWC_STAB ||
         st_ff.state == hwc_pkg::HWC_PLL)) begin
      nxt_st.resume_reset = st_ff.by_reset;
      nxt_st.resume_irq = !st_ff.by_reset;
      nxt_st.clk.cpu_run = 1'b1;
      nxt_st.clk.periph_clk = 1'b1;
      nxt_st.clk.timer_clk = 1'b1;
      nxt_st.clk.pll_clk = st_ff.cfg[`HWC_CFG_PLLEN];
    end

    // Wake delay sets flag and interrupt; set wins over read clear
    if (expire && st_ff.state == hwc_pkg::HWC_WAKE) begin
      nxt_st.wake_flag = 1'b1;
      nxt_st.wake_irq = 1'b1;
    end

    // RC oscillator enable and capture routing
    nxt_st.clk.rc_en = (nxt_st.state == hwc_pkg::HWC_WAKE) ||
                       (nxt_st.meas_en && nxt_st.state == hwc_pkg::HWC_RUN);
    nxt_st.cap_route = nxt_st.meas_en &&
                       nxt_st.state == hwc_pkg::HWC_RUN && st_ff.rc_s2;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  hwc_cycle_timer u_timer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .start_in(tmr_start),
    .load_in(tmr_load),
    .done_out(tmr_done)
  );

  // Wake delay of 64 times prescaler RC half-periods (each RC clock edge is one tick)
  hwc_wake_divider u_wake_div (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .run_in(st_ff.state == hwc_pkg::HWC_WAKE),
    .tick_in(rc_tick),
    .prescaler_in(st_ff.prescaler),
    .expire_out(expire)
  );

  assign wb_dat_out = {24'h000000, st_ff.rdata};
  assign wb_ack_out = st_ff.ack;
  assign clk_ctrl_out = st_ff.clk;
  assign cap_route_out = st_ff.cap_route;
  assign clr_mask_out = st_ff.clr_mask;
  assign int_mask_out = st_ff.mask;
  assign resume_reset_out = st_ff.resume_reset;
  assign resume_irq_out = st_ff.resume_irq;
  assign wdg_reset_out = st_ff.wdg_rst;
  assign wake_irq_out = st_ff.wake_irq;

  // Cycles spent in stabilisation, for checking only
  logic [`HWC_TMR_W-1:0] stab_cnt_ff;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stab_cnt_ff <= '0;
    end else if (st_ff.state == hwc_pkg::HWC_STAB) begin
      stab_cnt_ff <= stab_cnt_ff + `HWC_TMR_W'(1);
    end else begin
      stab_cnt_ff <= '0;
    end
  end

  AST_TIMED_ENTRY: assert property (
    st_ff.state == hwc_pkg::HWC_RUN && halt_op && timed_en &&
    !st_ff.wake_en |=> st_ff.state == hwc_pkg::HWC_TIMED)
    else $error("timed halt not entered");
  AST_STAB_LEN: assert property (
    st_ff.state == hwc_pkg::HWC_STAB && tmr_done |->
    stab_cnt_ff == stab_len)
    else $error("stabilisation length wrong");
  AST_IRQ_NOW: assert property (
    st_ff.state == hwc_pkg::HWC_TIMED && !wake_src_in.reset_req &&
    wake_src_in.irq_real_time_base1_interrupt |=> resume_irq_out && clk_ctrl_out.cpu_run)
    else $error("timed halt interrupt did not resume at once");
  AST_MASK_CLR: assert property (
    $changed(st_ff.state) && $past(st_ff.state) == hwc_pkg::HWC_RUN |->
    clr_mask_out && int_mask_out == 2'b00)
    else $error("mask not cleared on halt entry");
  AST_TIMED_CLKS: assert property (
    st_ff.state == hwc_pkg::HWC_TIMED |->
    clk_ctrl_out.main_osc && clk_ctrl_out.timer_clk &&
    !clk_ctrl_out.periph_clk && !clk_ctrl_out.cpu_run)
    else $error("wrong clocks in timed halt");
  AST_NO_WDG: assert property (
    st_ff.state == hwc_pkg::HWC_RUN && halt_op && timed_en |=>
    !wdg_reset_out)
    else $error("watchdog reset in timed halt");
  AST_WAKE_OSC: assert property (
    st_ff.state == hwc_pkg::HWC_WAKE |->
    clk_ctrl_out.rc_en && !clk_ctrl_out.main_osc)
    else $error("oscillators wrong in self-wake halt");
  AST_FLAG_SET: assert property (
    st_ff.state == hwc_pkg::HWC_WAKE && expire |=>
    st_ff.wake_flag && wake_irq_out ##1 st_ff.state == hwc_pkg::HWC_STAB)
    else $error("wake expiry not flagged");
  AST_READ_CLR: assert property (
    csr_read && !expire |=> !st_ff.wake_flag && !wake_irq_out)
    else $error("read did not clear wake flag");
  AST_WDG_OPT: assert property (
    st_ff.state == hwc_pkg::HWC_RUN && halt_op && wdg_active_in &&
    !timed_en && st_ff.cfg[`HWC_CFG_WDGOPT] |=>
    wdg_reset_out && st_ff.state == hwc_pkg::HWC_RUN)
    else $error("watchdog reset option ignored");

  COV_TIMED_IRQ: cover property (
    st_ff.state == hwc_pkg::HWC_TIMED ##1 resume_irq_out);
  COV_WAKE_EXPIRE: cover property (
    st_ff.state == hwc_pkg::HWC_WAKE && expire);
  COV_RESET_RESUME: cover property ($rose(resume_reset_out));
  COV_WDG: cover property ($rose(wdg_reset_out));

endmodule // hwc_halt_ctrl

// ==== inc/hwc_params.svh ====
`ifndef HWC_PARAMS_SVH
`define HWC_PARAMS_SVH

// Register indices; byte address is four times the index
`define HWC_IDX_PRESCALER 8'h49
`define HWC_IDX_CSR 8'h4a
`define HWC_IDX_CFG 8'h4b
`define HWC_IDX_STAT 8'h4c

// Reset values
`define HWC_PRESCALER_RST 8'hff
`define HWC_CFG_RST 7'h00

// Control/status bit positions
`define HWC_CSR_FLAG 2
`define HWC_CSR_MEAS 1
`define HWC_CSR_EN 0

// Configuration bit positions
`define HWC_CFG_TIME_BASE1_INT_ENABLE 0
`define HWC_CFG_OVERFLOW_INT_ENABLE 1
`define HWC_CFG_CK0 2
`define HWC_CFG_CK1 3
`define HWC_CFG_WDGOPT 4
`define HWC_CFG_PLLEN 5
`define HWC_CFG_LONG 6

`define HWC_HALT_OPCODE 8'h8e

// Timing
`define HWC_CLK_PERIOD_NS 8
`define HWC_PLL_STARTUP_NS 1000
`define HWC_STAB_SHORT 13'd256
`define HWC_STAB_LONG 13'd4096
`define HWC_FIXED_DIV 64
`define HWC_TMR_W 13

`endif

// ==== inc/hwc_pkg.sv ====
package hwc_pkg;

  typedef enum logic [2:0] {
    HWC_RUN, HWC_PLAIN, HWC_TIMED, HWC_WAKE, HWC_STAB, HWC_PLL
  } hwc_state_t;

  typedef struct packed {
    logic main_osc;
    logic timer_clk;
    logic periph_clk;
    logic pll_clk;
    logic rc_en;
    logic cpu_run;
  } hwc_clk_ctrl_t;

  typedef struct packed {
    logic reset_req;
    logic irq_halt_exit;
    logic irq_real_time_base1_interrupt;
    logic irq_active_exit;
  } hwc_wake_src_t;

  typedef struct packed {
    logic [12:0] cnt;
    logic busy;
    logic done;
  } hwc_tmr_st_t;

  typedef struct packed {
    logic [5:0] fix_cnt;
    logic [7:0] pre_cnt;
    logic expire;
  } hwc_div_st_t;

  typedef struct packed {
    hwc_state_t state;
    logic [7:0] prescaler;
    logic wake_en;
    logic meas_en;
    logic wake_flag;
    logic wake_irq;
    logic [6:0] cfg;
    logic ack;
    logic [7:0] rdata;
    logic [1:0] mask;
    logic clr_mask;
    logic resume_reset;
    logic resume_irq;
    logic wdg_rst;
    logic by_reset;
    logic cap_route;
    hwc_clk_ctrl_t clk;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
  } hwc_top_st_t;

endpackage

// ==== hdl/hwc_cycle_timer.sv ====
`timescale 1ns/10ps
`include "hwc_params.svh"

module hwc_cycle_timer (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [`HWC_TMR_W-1:0] load_in,
  output logic done_out
);

  hwc_pkg::hwc_tmr_st_t st_ff;
  hwc_pkg::hwc_tmr_st_t nxt_st;

  // Done pulses exactly load_in cycles after the start edge
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start_in) begin
      nxt_st.cnt = load_in;
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy) begin
      nxt_st.cnt = st_ff.cnt - 13'd1;
      if (st_ff.cnt == 13'd1) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done_out = st_ff.done;

endmodule // hwc_cycle_timer

// ==== hdl/hwc_wake_divider.sv ====
`timescale 1ns/10ps
`include "hwc_params.svh"

module hwc_wake_divider (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [7:0] prescaler_in,
  output logic expire_out
);

  hwc_pkg::hwc_div_st_t st_ff;
  hwc_pkg::hwc_div_st_t nxt_st;

  // Fixed divide by 64, then divide by the prescaler value
  always_comb begin
    nxt_st = st_ff;
    nxt_st.expire = 1'b0;
    if (!run_in) begin
      nxt_st.fix_cnt = '0;
      nxt_st.pre_cnt = '0;
    end else if (tick_in) begin
      nxt_st.fix_cnt = st_ff.fix_cnt + 6'd1;
      if (st_ff.fix_cnt == 6'(`HWC_FIXED_DIV - 1)) begin
        nxt_st.fix_cnt = '0;
        if (st_ff.pre_cnt + 8'd1 >= prescaler_in) begin
          nxt_st.pre_cnt = '0;
          nxt_st.expire = 1'b1;
        end else begin
          nxt_st.pre_cnt = st_ff.pre_cnt + 8'd1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expire_out = st_ff.expire;

endmodule // hwc_wake_divider

// ==== tb/hwc_rc_osc.sv ====
`timescale 1ns/10ps

module hwc_rc_osc #(
  parameter int HALF_NS = 20
) (
  input wire logic en_in,
  output logic rc_clk_out
);
  initial rc_clk_out = 1'h0;
  always begin
    #(HALF_NS);
    if (en_in) begin
      rc_clk_out = ~rc_clk_out;
    end
  end
endmodule // hwc_rc_osc

// ==== tb/hwc_halt_ctrl_bench.sv ====
`timescale 1ns/10ps
`include "hwc_params.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s exp %0h got %0h", nm, e, g); end end

module hwc_halt_ctrl_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [9:0] adr = 10'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, opv = 1'h0, wdg = 1'h0, ie = 1'h0, pop = 1'h0;
  logic [7:0] opc = 8'h0;
  logic [1:0] il = 2'h0, pm = 2'h0, mask;
  hwc_pkg::hwc_wake_src_t ws = '0;
  hwc_pkg::hwc_clk_ctrl_t ck;
  logic rc, cap, clrm, rres, rirq, wrst, wirq;
  logic [7:0] q;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  localparam logic [9:0] PRE = 10'h124, CSR = 10'h128, CFG = 10'h12c;
  localparam logic [9:0] STAT = 10'h130;

  always #4 clk = ~clk;

  hwc_rc_osc rc_u (.en_in(ck.rc_en), .rc_clk_out(rc));

  hwc_halt_ctrl #(.PLL_STARTUP_NS(80)) dut_u (
    .clk_in(clk), .arst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .opcode_valid_in(opv),
    .opcode_in(opc), .wdg_active_in(wdg), .wake_src_in(ws),
    .irq_entry_in(ie), .irq_level_in(il), .cc_pop_in(pop),
    .cc_pop_mask_in(pm), .wake_rc_clk_in(rc), .clk_ctrl_out(ck),
    .cap_route_out(cap), .clr_mask_out(clrm), .int_mask_out(mask),
    .resume_reset_out(rres), .resume_irq_out(rirq),
    .wdg_reset_out(wrst), .wake_irq_out(wirq));

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k = 0;
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a;
    wdat <= {24'h0, d}; sel <= 4'h1;
    do begin @(posedge clk); k++; end while (ack !== 1'h1 && k < 20);
    `CHK("bus ack", 1'h1, ack)
    q = rdat[7:0];
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0; sel <= 4'h0;
    @(posedge clk);
  endtask

  task rchk(input logic [9:0] a, input logic [7:0] e, input string nm);
    wb(1'h0, a, 8'h0);
    `CHK(nm, e, q)
  endtask

  task halt(input logic [7:0] o);
    opv <= 1'h1; opc <= o;
    @(posedge clk);
    opv <= 1'h0;
    @(posedge clk);
  endtask

  task wres;
    n = 0;
    while (rres !== 1'h1 && rirq !== 1'h1 && n < 6000) begin
      @(posedge clk); n++;
    end
  endtask

  task t_reset;
    `CHK("main_osc", 1'h1, ck.main_osc)
    `CHK("rc_en", 1'h0, ck.rc_en)
    rchk(CSR, 8'h00, "csr");
    rchk(PRE, 8'hff, "prescaler");
    rchk(CFG, 8'h00, "config");
    rchk(10'h3fc, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task t_mask;
    ie <= 1'h1; il <= 2'h2; @(posedge clk); ie <= 1'h0; @(posedge clk);
    `CHK("mask entry", 2'h2, mask)
    pop <= 1'h1; pm <= 2'h1; @(posedge clk); pop <= 1'h0; @(posedge clk);
    `CHK("mask pop", 2'h1, mask)
    rchk(STAT, 8'h08, "status");
    $display("test mask done");
  endtask

  task automatic t_modes;
    logic [7:0] cf [4] = '{8'h11, 8'h16, 8'h0e, 8'h02};
    logic tm [4] = '{1'h1, 1'h1, 1'h0, 1'h0};
    halt(8'h8f);
    `CHK("cpu_run", 1'h1, ck.cpu_run)
    wdg <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, CFG, cf[i]);
      halt(8'h8e);
      `CHK("wdg_reset", 1'h0, wrst)
      `CHK("main_osc", tm[i], ck.main_osc)
      `CHK("clr_mask", 1'h1, clrm)
      `CHK("mask", 2'h0, mask)
      ws.reset_req <= 1'h1; @(posedge clk); ws.reset_req <= 1'h0;
      wres();
      `CHK("resume_reset", 1'h1, rres)
      `CHK("stab", 1'h1, logic'(n >= 256 && n <= 260))
    end
    wdg <= 1'h0;
    $display("test modes done");
  endtask

  task t_timed;
    wb(1'h1, CFG, 8'h01);
    halt(8'h8e);
    `CHK("timer_clk", 1'h1, ck.timer_clk)
    `CHK("periph_clk", 1'h0, ck.periph_clk)
    ws.irq_halt_exit <= 1'h1; repeat (3) @(posedge clk);
    `CHK("cpu_run", 1'h0, ck.cpu_run)
    ws.irq_halt_exit <= 1'h0; ws.irq_real_time_base1_interrupt <= 1'h1;
    @(posedge clk); ws.irq_real_time_base1_interrupt <= 1'h0; @(posedge clk);
    `CHK("resume_irq", 1'h1, rirq)
    `CHK("cpu_run", 1'h1, ck.cpu_run)
    halt(8'h8e);
    ws.irq_active_exit <= 1'h1;
    @(posedge clk);
    ws.irq_active_exit <= 1'h0;
    @(posedge clk);
    `CHK("resume_irq", 1'h1, rirq)
    $display("test timed done");
  endtask

  task t_wdg;
    wb(1'h1, CFG, 8'h10);
    wdg <= 1'h1;
    halt(8'h8e);
    `CHK("wdg_reset", 1'h1, wrst)
    `CHK("cpu_run", 1'h1, ck.cpu_run)
    wdg <= 1'h0;
    $display("test watchdog done");
  endtask

  task t_wake;
    wb(1'h1, CFG, 8'h00);
    wb(1'h1, PRE, 8'h00);
    rchk(PRE, 8'hff, "prescaler");
    wb(1'h1, PRE, 8'h01);
    wb(1'h1, CSR, 8'hff);
    rchk(CSR, 8'h03, "csr");
    wb(1'h1, CSR, 8'h01);
    halt(8'h8e);
    `CHK("main_osc", 1'h0, ck.main_osc)
    `CHK("rc_en", 1'h1, ck.rc_en)
    `CHK("mask", 2'h0, mask)
    n = 0;
    while (wirq !== 1'h1 && n < 1000) begin @(posedge clk); n++; end
    `CHK("wake_irq", 1'h1, wirq)
    `CHK("wake delay", 1'h1, logic'(n >= 158 && n <= 172))
    `CHK("main_osc", 1'h1, ck.main_osc)
    wres();
    `CHK("resume_irq", 1'h1, rirq)
    `CHK("stab", 1'h1, logic'(n >= 254))
    rchk(CSR, 8'h05, "csr flag");
    `CHK("wake_irq", 1'h0, wirq)
    rchk(CSR, 8'h01, "csr cleared");
    wb(1'h1, CSR, 8'h02);
    n = 0;
    repeat (40) begin @(posedge clk); n += int'(cap); end
    `CHK("rc_en", 1'h1, ck.rc_en)
    `CHK("capture", 1'h1, logic'(n > 0 && n < 40))
    wb(1'h1, CSR, 8'h00);
    repeat (3) @(posedge clk);
    `CHK("capture", 1'h0, cap)
    $display("test wake done");
  endtask

  task t_pll;
    wb(1'h1, CFG, 8'h60);
    halt(8'h8e);
    `CHK("main_osc", 1'h0, ck.main_osc)
    ws.irq_halt_exit <= 1'h1; @(posedge clk); ws.irq_halt_exit <= 1'h0;
    wres();
    `CHK("resume_irq", 1'h1, rirq)
    `CHK("long stab", 1'h1, logic'(n >= 4106 && n <= 4115))
    `CHK("pll_clk", 1'h1, ck.pll_clk)
    $display("test pll done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_mask();
    t_modes();
    t_timed();
    t_wdg();
    t_wake();
    t_pll();
    end_sim();
  end
endmodule // hwc_halt_ctrl_bench
